/* hdl/bert_cfg_pkg.sv */
// Package of the tester configuration and pattern block.
// Assumes a single core clock; the host port is the framer's 8-bit register port.
package bert_cfg_pkg;

    // ========================================================================
    // Register offsets on the 8-bit host port
    localparam logic [7:0] OFS_PATTERN_SELECT      = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK_AND_LENGTH = 8'h41;
    localparam logic [7:0] OFS_ERROR_INSERT_LOAD   = 8'h42;

    // ========================================================================
    // Field positions
    localparam int POS_PATTERN_SELECT_LSB = 2;
    localparam int POS_SYNC_CHANGE_IRQ_EN = 7;
    localparam int POS_BIT_ERROR_IRQ_EN   = 6;
    localparam int POS_OVERFLOW_IRQ_EN    = 5;
    localparam int POS_REP_LENGTH_LSB     = 0;
    localparam int POS_AUTO_ERR_RATE_LSB  = 5;
    localparam int POS_SINGLE_ERR_INJECT  = 4;
    localparam int POS_PATTERN_LOAD       = 0;

    // ========================================================================
    // Reset values
    localparam logic [2:0] RST_PATTERN_SELECT = 3'h0;
    localparam logic [2:0] RST_IRQ_EN         = 3'h0;
    localparam logic [3:0] RST_REP_LENGTH     = 4'h0;
    localparam logic [2:0] RST_AUTO_ERR_RATE  = 3'h0;
    localparam logic [19:0] LFSR_SEED         = 20'hfffff;

    // ========================================================================
    // Pattern select codes
    localparam logic [2:0] PAT_PRBS7    = 3'h0;
    localparam logic [2:0] PAT_PRBS11   = 3'h1;
    localparam logic [2:0] PAT_PRBS15   = 3'h2;
    localparam logic [2:0] PAT_QRSS     = 3'h3;
    localparam logic [2:0] PAT_REPEAT   = 3'h4;
    localparam logic [2:0] PAT_ALT_WORD = 3'h5;
    localparam logic [2:0] PAT_OCTET55  = 3'h6;
    localparam logic [2:0] PAT_RESERVED = 3'h7;

    // ========================================================================
    // Pattern geometry and counts
    localparam logic [4:0] REP_LENGTH_BASE = 5'd16;   // Last index of a 17-bit pattern
    localparam logic [5:0] REP_LENGTH_MIN  = 6'd17;
    localparam logic [3:0] QRSS_MAX_ZEROS  = 4'd14;
    localparam logic [5:0] OCTET_COUNT     = 6'd55;
    localparam logic [3:0] ALT_WORD_LAST   = 4'd15;

    // Bits between automatic errors for rates one in ten to one in ten million
    function automatic logic [23:0] err_period(input logic [2:0] rate);
        case (rate)
            3'h1:    err_period = 24'd10;
            3'h2:    err_period = 24'd100;
            3'h3:    err_period = 24'd1000;
            3'h4:    err_period = 24'd10000;
            3'h5:    err_period = 24'd100000;
            3'h6:    err_period = 24'd1000000;
            3'h7:    err_period = 24'd10000000;
            default: err_period = 24'd0;
        endcase
    endfunction

endpackage

/* hdl/bert_octet_rom.sv */
// Constant table of the 55 octets of the byte-aligned test pattern.
// Assumes the caller presents an index below DEPTH; read data are registered.
`timescale 1ns/10ps
`default_nettype none

module bert_octet_rom #(
    parameter int               DEPTH  = 55,
    parameter logic [8*55-1:0]  OCTETS = {55{8'h80}}
) (
    input  wire logic       clk,
    input  wire logic [5:0] addr,
    output var  logic [7:0] data
);

    // ========================================================================
    // Registered lookup
    always_ff @(posedge clk) begin
        if (int'(addr) < DEPTH) begin
            data <= OCTETS[8*addr +: 8];
        end else begin
            data <= 8'h00;
        end
    end

endmodule

`default_nettype wire

/* hdl/bert_pattern_config.sv */
// Tester configuration registers, pattern generator and error insertion.
// Assumes host strobes, line bit strobe, timeslot marks and checker events share CORE_CLK.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Codes 0-2 pick 2^7, 2^11, 2^15 sequences
// - Code 3 is 2^20 sequence, max 14 zeros
// - Codes 4,5,6 repeat, alternate, 55 octets; 7 reserved
// - 55 octets repeat, byte aligned in timeslots
// - Repeat length is 17 plus field value
// - Checker ignores length field for pseudorandom sequences
// - One mask bit per receiver event
// - Error field zero off, else one in 10^n
module bert_pattern_config
    import bert_cfg_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  BUS_ADDR,
    input  wire logic        BUS_WR,
    input  wire logic        BUS_RD,
    input  wire logic [7:0]  BUS_WDATA,
    output logic      [7:0]  BUS_RDATA,
    input  wire logic [31:0] REP_PATTERN,
    input  wire logic [7:0]  ALT_WORD_COUNT,
    input  wire logic        BIT_STROBE,
    input  wire logic        TS_ACTIVE,
    input  wire logic        BYTE_START,
    input  wire logic        SYNC_CHANGE,
    input  wire logic        BIT_ERROR_SEEN,
    input  wire logic        COUNTER_OVERFLOW,
    output logic             TX_BIT,
    output logic             TX_VALID,
    output logic      [2:0]  RX_PATTERN_SEL,
    output logic      [5:0]  RX_REP_LENGTH,
    output logic             EVENT_IRQ
);

    // ========================================================================
    // Host registers
    logic [2:0] pat_sel_r, pat_sel_nxt;
    logic [2:0] irq_en_r, irq_en_nxt;
    logic [3:0] rep_len_r, rep_len_nxt;
    logic [2:0] err_rate_r, err_rate_nxt;
    logic       single_err_r, single_err_nxt;
    logic       load_trig_r, load_trig_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // Next values of the host registers and read data
    always_comb begin
        pat_sel_nxt    = pat_sel_r;
        irq_en_nxt     = irq_en_r;
        rep_len_nxt    = rep_len_r;
        err_rate_nxt   = err_rate_r;
        single_err_nxt = single_err_r;
        load_trig_nxt  = load_trig_r;
        rdata_nxt      = rdata_r;
        if (BUS_WR) begin
            unique case (BUS_ADDR)
                OFS_PATTERN_SELECT: begin
                    pat_sel_nxt = BUS_WDATA[POS_PATTERN_SELECT_LSB +: 3];
                end
                OFS_IRQ_MASK_AND_LENGTH: begin
                    irq_en_nxt  = {BUS_WDATA[POS_SYNC_CHANGE_IRQ_EN],
                                   BUS_WDATA[POS_BIT_ERROR_IRQ_EN],
                                   BUS_WDATA[POS_OVERFLOW_IRQ_EN]};
                    rep_len_nxt = BUS_WDATA[POS_REP_LENGTH_LSB +: 4];
                end
                OFS_ERROR_INSERT_LOAD: begin
                    err_rate_nxt   = BUS_WDATA[POS_AUTO_ERR_RATE_LSB +: 3];
                    single_err_nxt = BUS_WDATA[POS_SINGLE_ERR_INJECT];
                    load_trig_nxt  = BUS_WDATA[POS_PATTERN_LOAD];
                end
                default: ;
            endcase
        end
        if (BUS_RD) begin
            unique case (BUS_ADDR)
                OFS_PATTERN_SELECT:      rdata_nxt = {3'h0, pat_sel_r, 2'h0};
                OFS_IRQ_MASK_AND_LENGTH: rdata_nxt = {irq_en_r, 1'b0, rep_len_r};
                OFS_ERROR_INSERT_LOAD:   rdata_nxt = {err_rate_r, single_err_r, 3'h0,
                                                      load_trig_r};
                default:                 rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register the host state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pat_sel_r    <= RST_PATTERN_SELECT;
            irq_en_r     <= RST_IRQ_EN;
            rep_len_r    <= RST_REP_LENGTH;
            err_rate_r   <= RST_AUTO_ERR_RATE;
            single_err_r <= 1'b0;
            load_trig_r  <= 1'b0;
            rdata_r      <= 8'h00;
        end else begin
            pat_sel_r    <= pat_sel_nxt;
            irq_en_r     <= irq_en_nxt;
            rep_len_r    <= rep_len_nxt;
            err_rate_r   <= err_rate_nxt;
            single_err_r <= single_err_nxt;
            load_trig_r  <= load_trig_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    // ========================================================================
    // Generator state
    logic        single_err_d_r, load_trig_d_r;
    logic [19:0] lfsr_r, lfsr_nxt;
    logic [3:0]  zero_run_r, zero_run_nxt;
    logic [4:0]  rep_idx_r, rep_idx_nxt;
    logic [7:0]  word_cnt_r, word_cnt_nxt;
    logic        word_sel_r, word_sel_nxt;
    logic [3:0]  word_bit_r, word_bit_nxt;
    logic [7:0]  octet_r, octet_nxt;
    logic [2:0]  octet_bit_r, octet_bit_nxt;
    logic [5:0]  octet_addr_r, octet_addr_nxt;
    logic        octet_live_r, octet_live_nxt;
    logic [23:0] err_cnt_r, err_cnt_nxt;
    logic        err_pend_r, err_pend_nxt;
    logic        tx_bit_nxt, tx_valid_nxt, irq_nxt;
    logic [5:0]  rx_len_nxt;
    logic [7:0]  octet_data;
    logic        load_pulse, single_pulse, adv, emit, raw, err_hit, fb;
    logic [4:0]  rep_last;
    logic [23:0] period;

    // Fixed table of the byte-aligned pattern
    bert_octet_rom #(
        .DEPTH (55)
    ) u_octets (
        .clk  (CORE_CLK),
        .addr (octet_addr_r),
        .data (octet_data)
    );

    // Edge detection of the trigger bits and the bit step
    assign load_pulse   = load_trig_r & ~load_trig_d_r;
    assign single_pulse = single_err_r & ~single_err_d_r;
    assign adv          = BIT_STROBE & TS_ACTIVE & (pat_sel_r != PAT_RESERVED);
    assign rep_last     = 5'(REP_LENGTH_BASE + {1'b0, rep_len_r});
    assign period       = err_period(err_rate_r);

    // Next state of the generator, error insertion and outputs
    always_comb begin
        lfsr_nxt       = lfsr_r;
        zero_run_nxt   = zero_run_r;
        rep_idx_nxt    = rep_idx_r;
        word_cnt_nxt   = word_cnt_r;
        word_sel_nxt   = word_sel_r;
        word_bit_nxt   = word_bit_r;
        octet_nxt      = octet_r;
        octet_bit_nxt  = octet_bit_r;
        octet_addr_nxt = octet_addr_r;
        octet_live_nxt = octet_live_r;
        err_cnt_nxt    = err_cnt_r;
        raw            = 1'b0;
        fb             = 1'b0;
        emit           = 1'b0;
        // Shift out MSB first, feedback enters at the LSB
        unique case (pat_sel_r)
            PAT_PRBS7:  begin raw = lfsr_r[6];  fb = lfsr_r[6]  ^ lfsr_r[5];  end
            PAT_PRBS11: begin raw = lfsr_r[10]; fb = lfsr_r[10] ^ lfsr_r[8];  end
            PAT_PRBS15: begin raw = lfsr_r[14]; fb = lfsr_r[14] ^ lfsr_r[13]; end
            PAT_QRSS: begin
                fb  = lfsr_r[19] ^ lfsr_r[16];
                raw = lfsr_r[19] | (zero_run_r == QRSS_MAX_ZEROS);  // Force a one
            end
            PAT_REPEAT:   raw = REP_PATTERN[rep_idx_r];
            PAT_ALT_WORD: raw = REP_PATTERN[{word_sel_r, word_bit_r}];
            PAT_OCTET55:  raw = BYTE_START ? octet_data[0] : octet_r[octet_bit_r];
            default:      raw = 1'b0;
        endcase
        if (adv) begin
            emit = (pat_sel_r != PAT_OCTET55) || BYTE_START || octet_live_r;
            lfsr_nxt     = {lfsr_r[18:0], fb};
            zero_run_nxt = (raw || pat_sel_r != PAT_QRSS) ? 4'h0 : 4'(zero_run_r + 4'h1);
            rep_idx_nxt  = (rep_idx_r >= rep_last) ? 5'h00 : 5'(rep_idx_r + 5'h01);
            word_bit_nxt = 4'(word_bit_r + 4'h1);
            if (word_bit_r == ALT_WORD_LAST) begin
                if (word_cnt_r == 8'h00) begin
                    word_cnt_nxt = 8'(ALT_WORD_COUNT - 8'h01);
                    word_sel_nxt = ~word_sel_r;
                end else begin
                    word_cnt_nxt = 8'(word_cnt_r - 8'h01);
                end
            end
            // Octets start only on a byte boundary of an active timeslot
            if (BYTE_START) begin
                octet_nxt      = octet_data;
                octet_bit_nxt  = 3'h1;
                octet_live_nxt = 1'b1;
                octet_addr_nxt = (octet_addr_r == 6'(OCTET_COUNT - 6'd1)) ? 6'h00
                                 : 6'(octet_addr_r + 6'h01);
            end else begin
                octet_bit_nxt = 3'(octet_bit_r + 3'h1);
            end
        end
        err_hit = emit && (err_rate_r != 3'h0) && (err_cnt_r >= 24'(period - 24'd1));
        if (emit) begin
            err_cnt_nxt = (err_hit || err_rate_r == 3'h0) ? 24'h0 : 24'(err_cnt_r + 24'h1);
        end
        if (load_pulse) begin
            lfsr_nxt       = LFSR_SEED;
            zero_run_nxt   = 4'h0;
            rep_idx_nxt    = 5'h00;
            word_cnt_nxt   = 8'(ALT_WORD_COUNT - 8'h01);
            word_sel_nxt   = 1'b0;
            word_bit_nxt   = 4'h0;
            octet_addr_nxt = 6'h00;
            octet_bit_nxt  = 3'h0;
            octet_live_nxt = 1'b0;
            err_cnt_nxt    = 24'h0;
        end
        // A new single error request wins over clearing the one being applied
        err_pend_nxt = single_pulse | (err_pend_r & ~emit);
        tx_bit_nxt   = emit ? (raw ^ (err_hit | err_pend_r)) : TX_BIT;
        tx_valid_nxt = emit;
        rx_len_nxt   = pat_sel_r[2] ? 6'(REP_LENGTH_MIN + {2'h0, rep_len_r}) : 6'h00;
        irq_nxt      = |({SYNC_CHANGE, BIT_ERROR_SEEN, COUNTER_OVERFLOW} & irq_en_r);
    end

    // Register the generator state and the outputs
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            single_err_d_r <= 1'b0;
            load_trig_d_r  <= 1'b0;
            lfsr_r         <= LFSR_SEED;
            zero_run_r     <= 4'h0;
            rep_idx_r      <= 5'h00;
            word_cnt_r     <= 8'h00;
            word_sel_r     <= 1'b0;
            word_bit_r     <= 4'h0;
            octet_r        <= 8'h00;
            octet_bit_r    <= 3'h0;
            octet_addr_r   <= 6'h00;
            octet_live_r   <= 1'b0;
            err_cnt_r      <= 24'h0;
            err_pend_r     <= 1'b0;
            TX_BIT         <= 1'b0;
            TX_VALID       <= 1'b0;
            RX_PATTERN_SEL <= RST_PATTERN_SELECT;
            RX_REP_LENGTH  <= 6'h00;
            EVENT_IRQ      <= 1'b0;
        end else begin
            single_err_d_r <= single_err_r;
            load_trig_d_r  <= load_trig_r;
            lfsr_r         <= lfsr_nxt;
            zero_run_r     <= zero_run_nxt;
            rep_idx_r      <= rep_idx_nxt;
            word_cnt_r     <= word_cnt_nxt;
            word_sel_r     <= word_sel_nxt;
            word_bit_r     <= word_bit_nxt;
            octet_r        <= octet_nxt;
            octet_bit_r    <= octet_bit_nxt;
            octet_addr_r   <= octet_addr_nxt;
            octet_live_r   <= octet_live_nxt;
            err_cnt_r      <= err_cnt_nxt;
            err_pend_r     <= err_pend_nxt;
            TX_BIT         <= tx_bit_nxt;
            TX_VALID       <= tx_valid_nxt;
            RX_PATTERN_SEL <= pat_sel_r;
            RX_REP_LENGTH  <= rx_len_nxt;
            EVENT_IRQ      <= irq_nxt;
        end
    end
    assign BUS_RDATA = rdata_r;

    // ========================================================================
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_single_rise;
        !single_err_r ##1 single_err_r;
    endsequence

    sequence s_load_rise;
        !load_trig_r ##1 load_trig_r;
    endsequence

    a_load_reseed: assert property (s_load_rise |=> lfsr_r == LFSR_SEED)
        else $error("Pattern load did not reseed the generator");
    a_load_once: assert property (load_trig_r && $past(load_trig_r) |-> !load_pulse)
        else $error("Pattern load retriggered without a clear");
    a_single_pend: assert property (s_single_rise |=> err_pend_r)
        else $error("Single error not queued");
    a_prbs7_tap: assert property (adv && pat_sel_r == PAT_PRBS7 && !load_pulse
        |=> lfsr_r[0] == ($past(lfsr_r[6]) ^ $past(lfsr_r[5])))
        else $error("Seven-stage feedback wrong");
    a_qrss_zeros: assert property (zero_run_r <= QRSS_MAX_ZEROS)
        else $error("Zero run longer than allowed");
    a_reserved_idle: assert property (pat_sel_r == PAT_RESERVED |=> !TX_VALID)
        else $error("Reserved select produced data");
    a_octet_wrap: assert property (adv && BYTE_START && !load_pulse
        && octet_addr_r == 6'd54 |=> octet_addr_r == 6'h00)
        else $error("Octet index did not wrap after 55");
    a_rep_wrap: assert property (adv && !load_pulse && rep_idx_r == rep_last
        |=> rep_idx_r == 5'h00)
        else $error("Repeat index did not wrap at length");
    a_rx_len_prbs: assert property (!pat_sel_r[2] |=> RX_REP_LENGTH == 6'h00)
        else $error("Length passed to checker in pseudorandom mode");
    a_irq_mask: assert property (EVENT_IRQ |-> $past(|({SYNC_CHANGE, BIT_ERROR_SEEN,
        COUNTER_OVERFLOW} & irq_en_r)))
        else $error("Masked event raised the interrupt");
    a_err_off: assert property (emit && err_rate_r == 3'h0 && !err_pend_r
        |=> TX_BIT == $past(raw))
        else $error("Error inserted while insertion is off");

endmodule

`default_nettype wire

/* sim/framer_path_model.sv */
// Behavioural model of the framer channel path feeding the tester.
// Assumes the bench clock and reset; strobes flow only while run is high.
`timescale 1ns/10ps
`default_nettype none

module framer_path_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      bit_strobe,
    output logic      ts_active,
    output logic      byte_start
);
    logic       ph_r;
    logic [4:0] pos_r;

    // ==========
    // Bit timing
    // One bit every other cycle; eight bits a slot, four slots a frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_r  <= 1'b0;
            pos_r <= 5'h00;
        end else if (run) begin
            ph_r <= ~ph_r;
            if (ph_r)
                pos_r <= pos_r + 5'h01;
        end
    end

    // Last slot of each frame is idle, so the generator must skip it
    assign bit_strobe = run & ph_r;
    assign ts_active  = (pos_r[4:3] != 2'h3);
    assign byte_start = bit_strobe & (pos_r[2:0] == 3'h0);  // Slot byte boundary
endmodule

`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench of the tester configuration and pattern block.
// Assumes the framer path model and the design package are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top
    import bert_cfg_pkg::*;
();
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] rd;
        logic [2:0] sel;
        logic [5:0] len;
    } row_t;
    logic        clk, rst, bus_wr, bus_rd, run, tx_bit, tx_valid, irq;
    logic        strobe, ts_act, byte_st;
    logic [7:0]  bus_addr, bus_wdata, bus_rdata, alt_cnt, rdv;
    logic [31:0] rep_pat;
    logic [2:0]  ev, rx_sel;
    logic [5:0]  rx_len;
    logic        q[$];
    int          error_cnt, num_checks, act_cnt, e, first, p, ones, mism, run_z, max_z;
    int          lens[4] = '{0, 5, 7, 15};
    int          pers[4] = '{0, 10, 100, 1000};
    row_t        rows[12] = '{
        '{8'h41, 8'h0f, 8'h0f, 3'h0, 6'h00}, '{8'h40, 8'h04, 8'h04, 3'h1, 6'h00},
        '{8'h40, 8'h08, 8'h08, 3'h2, 6'h00}, '{8'h40, 8'h0c, 8'h0c, 3'h3, 6'h00},
        '{8'h40, 8'h10, 8'h10, 3'h4, 6'h20}, '{8'h41, 8'hff, 8'hef, 3'h4, 6'h20},
        '{8'h41, 8'h00, 8'h00, 3'h4, 6'h11}, '{8'h40, 8'h14, 8'h14, 3'h5, 6'h11},
        '{8'h40, 8'hff, 8'h1c, 3'h7, 6'h11}, '{8'h40, 8'h18, 8'h18, 3'h6, 6'h11},
        '{8'h43, 8'h5a, 8'h00, 3'h6, 6'h11}, '{8'h42, 8'hee, 8'he0, 3'h6, 6'h11}};

    bert_pattern_config u_dut (
        .CORE_CLK(clk), .RST(rst), .BUS_ADDR(bus_addr), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
        .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata), .REP_PATTERN(rep_pat),
        .ALT_WORD_COUNT(alt_cnt), .BIT_STROBE(strobe), .TS_ACTIVE(ts_act),
        .BYTE_START(byte_st), .SYNC_CHANGE(ev[0]), .BIT_ERROR_SEEN(ev[1]),
        .COUNTER_OVERFLOW(ev[2]), .TX_BIT(tx_bit), .TX_VALID(tx_valid),
        .RX_PATTERN_SEL(rx_sel), .RX_REP_LENGTH(rx_len), .EVENT_IRQ(irq));

    framer_path_model u_path (.clk(clk), .rst(rst), .run(run), .bit_strobe(strobe),
                              .ts_active(ts_act), .byte_start(byte_st));

    // ==========
    // Clock, capture of generated bits and count of active strobes
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (tx_valid === 1'b1)
            q.push_back(tx_bit);
        if (strobe && ts_act)
            act_cnt++;
    end

    // ==========
    // Host port cycles and stream helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(posedge clk);
        #1 d = bus_rdata;
    endtask

    // Sets the pattern, pulses the load bit and empties the capture
    task automatic load(input logic [7:0] v, input logic [31:0] pat);
        @(posedge clk);
        rep_pat <= pat;
        wr(8'h42, v | 8'h01);
        wr(8'h42, v);
        repeat (3) @(posedge clk);
        q.delete();
        act_cnt = 0;
    endtask

    task automatic run_bits(input int n);
        int k;
        k = 0;
        @(posedge clk);
        run <= 1'b1;
        while (q.size() < n && k < 50 * n) begin
            @(posedge clk);
            k++;
        end
        run <= 1'b0;
        repeat (4) @(posedge clk);
        if (k >= 50 * n) begin
            error_cnt++;
            finish_test();
        end
    endtask

    // Finds where the capture departs from a repeating pattern
    task automatic chk_rep(input int len, input int per, output int n, output int f);
        int last;
        n = 0;
        f = -1;
        last = -1;
        foreach (q[i]) begin
            if (q[i] !== rep_pat[i % len]) begin
                if (per != 0 && last >= 0)
                    `CHK(i - last, per)
                if (f < 0)
                    f = i;
                last = i;
                n++;
            end
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========
    // Main sequence
    initial begin
        rst = 1'b1;
        {bus_wr, bus_rd, run, ev} = '0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        alt_cnt = 8'h01;
        rep_pat = 32'h8d3a61c5;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 `CHK({tx_valid, irq, rx_sel, rx_len, bus_rdata}, 19'h00000)
        rd(8'h41, rdv);
        `CHK(rdv, {RST_IRQ_EN, 1'b0, RST_REP_LENGTH})
        rd(8'h42, rdv);
        `CHK(rdv, {RST_AUTO_ERR_RATE, 5'h00})
        // Register table rows: read-back, selected pattern and length
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rdv);
            `CHK(rdv, rows[i].rd)
            `CHK(rx_sel, rows[i].sel)
            `CHK(rx_len, rows[i].len)
        end
        // Repeat lengths at both ends, with automatic errors off and on
        for (int r = 0; r < 4; r++) begin
            wr(8'h40, 8'h10);
            wr(8'h41, 8'(lens[r]));
            load(8'(r << 5), (r == 2) ? 32'hb6db6db6 : 32'h8d3a61c5);  // Period 3 in 24
            run_bits((r == 0) ? 60 : pers[r] * 5 / 2);
            chk_rep(17 + lens[r], pers[r], e, first);
            `CHK((r == 0) ? (e == 0) : (e >= 2 && first < pers[r]), 1'b1)
            `CHK(act_cnt, q.size())
        end
        // Single error needs a fresh rising edge each time
        wr(8'h41, 8'h00);
        load(8'h00, 32'h8d3a61c5);
        wr(8'h42, 8'h10);
        run_bits(20);
        wr(8'h42, 8'h10);
        run_bits(40);
        chk_rep(17, 0, e, first);
        `CHK({e, first}, {32'h1, 32'h0})
        wr(8'h42, 8'h00);
        wr(8'h42, 8'h10);
        run_bits(60);
        chk_rep(17, 0, e, first);
        `CHK(e, 2)
        // Alternating words, one word per alternation
        wr(8'h40, 8'h14);
        load(8'h00, 32'h5a5a0f0f);
        run_bits(70);
        chk_rep(32, 0, e, first);
        `CHK(e, 0)
        // Two words per alternation: A, A, B, B
        alt_cnt <= 8'h02;
        load(8'h00, 32'h5a5a0f0f);
        run_bits(130);
        mism = 0;
        for (int i = 0; i < 128; i++)
            mism += int'(q[i] !== rep_pat[16 * ((i / 32) % 2) + i % 16]);
        `CHK(mism, 0)
        // Short sequences: full period, balance and repetition
        for (int s = 0; s < 2; s++) begin
            p = (s == 0) ? 127 : 2047;
            wr(8'h40, 8'(s << 2));
            load(8'h00, 32'hffffffff);  // All ones before pseudorandom runs
            run_bits(2 * p);
            ones = 0;
            mism = 0;
            for (int i = 0; i < p; i++) begin
                ones += int'(q[i]);
                mism += int'(q[i] !== q[i + p]);
            end
            `CHK(ones, (p + 1) / 2)
            `CHK(mism, 0)
        end
        // Long sequence keeps zero runs short
        wr(8'h40, 8'h0c);
        load(8'h00, 32'hffffffff);
        run_bits(3000);
        run_z = 0;
        max_z = 0;
        foreach (q[i]) begin
            run_z = (q[i] === 1'b0) ? run_z + 1 : 0;
            max_z = (run_z > max_z) ? run_z : max_z;
        end
        `CHK(max_z <= 14 && max_z > 0, 1'b1)
        // Octet table, low bit first, aligned to slot bytes
        wr(8'h40, 8'h18);
        load(8'h00, 32'hffffffff);
        run_bits(48);
        mism = 0;
        foreach (q[i])
            mism += int'(q[i] !== (i % 8 == 7));
        `CHK(mism, 0)
        // Reserved code sends nothing
        wr(8'h40, 8'h1c);
        load(8'h00, 32'hffffffff);
        @(posedge clk);
        run <= 1'b1;
        repeat (64) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(q.size(), 0)
        // Each event alone, own mask set or the other two set
        for (int k = 0; k < 6; k++) begin
            wr(8'h41, (k % 2 == 1) ? (8'h80 >> (k / 2)) : (8'he0 & ~(8'h80 >> (k / 2))));
            @(posedge clk);
            ev <= 3'h1 << (k / 2);
            @(posedge clk);
            ev <= 3'h0;
            #1 e = int'(irq);
            repeat (2) begin
                @(posedge clk);
                #1 e += int'(irq);
            end
            `CHK(e, k % 2)
        end
        // Reset in mid-stream
        wr(8'h40, 8'h10);
        @(posedge clk);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b1;
        run <= 1'b0;
        @(posedge clk);
        #1 `CHK({tx_valid, irq, rx_sel, rx_len}, 11'h000)
        @(posedge clk);
        rst <= 1'b0;
        rd(8'h40, rdv);
        `CHK(rdv, 8'h00)
        finish_test();
    end
endmodule

`default_nettype wire
